// ==== core_decode_pkg.sv ====
// ==========================================================================
// shared constants and types
// ==========================================================================
package core_decode_pkg;

   localparam int INSTR_W = 14;
   localparam int PC_W    = 13;
   localparam int DATA_W  = 8;
   localparam int FADDR_W = 7;
   localparam int LIT_W   = 11;
   localparam int LATCH_W = 8;

   // ========================================================================
   // instruction fields
   // ========================================================================
   localparam int OPC_JUMP_LSB = 11;
   localparam int OPC_INC_LSB  = 8;
   localparam int DEST_BIT     = 7;
   localparam int LATCH_HI     = 4;
   localparam int LATCH_LO     = 3;

   localparam logic [2:0]         OPC_JUMP  = 3'h5;
   localparam logic [5:0]         OPC_INC   = 6'h0a;
   localparam logic [INSTR_W-1:0] IDLE_MASK = 14'h3f9f;
   localparam logic [INSTR_W-1:0] IDLE_CODE = 14'h0000;

   // ========================================================================
   // reset values and timing
   // ========================================================================
   localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;
   localparam logic [PC_W-1:0]   PC_ONE     = 13'h0001;

   // system clocks per phase; one instruction cycle is four phases
   localparam int         PHASE_DIV  = 2;
   localparam logic [0:0] DIV_LAST   = 1'h1;
   localparam logic [0:0] DIV_RESET  = 1'h0;
   localparam logic [0:0] DIV_ONE    = 1'h1;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } phase_e;

   typedef enum logic {
      CYC_EXEC  = 1'b0,
      CYC_FLUSH = 1'b1
   } cycle_e;

   typedef enum logic [1:0] {
      OPK_IDLE  = 2'b00,
      OPK_JUMP  = 2'b01,
      OPK_INC   = 2'b11,
      OPK_OTHER = 2'b10
   } op_kind_e;

   typedef struct packed {
      logic               we;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0]  wdata;
   } file_port_s;

endpackage : core_decode_pkg

// ==== q_phase_seq.sv ====
`timescale 1ns/10ps
// ==========================================================================
// four-phase sequencer with clock-enable divider
// ==========================================================================
module q_phase_seq (
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_reset_n,
   // phase outputs
   output core_decode_pkg::phase_e    o_phase,
   output logic                       o_step
);

   logic [0:0]               div_cnt;
   logic [0:0]               next_div_cnt;
   core_decode_pkg::phase_e  next_phase;

   // step marks the last system clock of the current phase
   assign o_step = (div_cnt == core_decode_pkg::DIV_LAST);

   always_comb begin
      next_div_cnt = o_step ? core_decode_pkg::DIV_RESET : div_cnt + core_decode_pkg::DIV_ONE;
      next_phase   = o_phase;
      if (o_step) begin
         case (o_phase)
            core_decode_pkg::PH_Q1: next_phase = core_decode_pkg::PH_Q2;
            core_decode_pkg::PH_Q2: next_phase = core_decode_pkg::PH_Q3;
            core_decode_pkg::PH_Q3: next_phase = core_decode_pkg::PH_Q4;
            core_decode_pkg::PH_Q4: next_phase = core_decode_pkg::PH_Q1;
            default:                next_phase = core_decode_pkg::PH_Q1;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         div_cnt <= core_decode_pkg::DIV_RESET;
         o_phase <= core_decode_pkg::PH_Q1;
      end else begin
         div_cnt <= next_div_cnt;
         o_phase <= next_phase;
      end
   end

endmodule : q_phase_seq

// ==== branch_increment_nop_decode.sv ====
// Function
// - jump recognised by top bits 101
// - jump literal loads pc bits 10..0
// - pc bits 12..11 from latch bits 4..3
// - jump takes two cycles, second idle
// - increment addressed register, update zero only
// - dest bit 0 to accumulator, 1 to file
// - increment completes in one instruction cycle
`timescale 1ns/10ps
module branch_increment_nop_decode (
   // clock and reset
   input  wire logic                                    i_sys_clk,
   input  wire logic                                    i_reset_n,
   // instruction fetch
   input  wire logic [core_decode_pkg::INSTR_W-1:0]     i_instr,
   input  wire logic [core_decode_pkg::LATCH_W-1:0]     i_pc_upper_latch,
   output logic      [core_decode_pkg::PC_W-1:0]        o_pc,
   // file register port
   input  wire logic [core_decode_pkg::DATA_W-1:0]      i_file_rdata,
   output core_decode_pkg::file_port_s                  o_file_req,
   // core state
   output logic      [core_decode_pkg::DATA_W-1:0]      o_w,
   output logic                                         o_zero,
   output core_decode_pkg::op_kind_e                    o_op_kind,
   output core_decode_pkg::cycle_e                      o_cycle
);

   // =======================================================================
   // phase sequencing
   // =======================================================================
   core_decode_pkg::phase_e phase;
   logic                    step;

   q_phase_seq u_phase (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .o_phase   (phase),
      .o_step    (step)
   );

   // =======================================================================
   // decode and execute
   // =======================================================================
   logic [core_decode_pkg::INSTR_W-1:0] ir;
   logic [core_decode_pkg::INSTR_W-1:0] next_ir;
   logic [core_decode_pkg::DATA_W-1:0]  operand;
   logic [core_decode_pkg::DATA_W-1:0]  next_operand;
   logic [core_decode_pkg::DATA_W-1:0]  result;
   logic [core_decode_pkg::DATA_W-1:0]  next_result;
   logic [core_decode_pkg::PC_W-1:0]    next_pc;
   logic [core_decode_pkg::DATA_W-1:0]  next_w;
   logic                                next_zero;
   core_decode_pkg::file_port_s         next_file_req;
   core_decode_pkg::op_kind_e           next_op_kind;
   core_decode_pkg::op_kind_e           decoded;
   core_decode_pkg::cycle_e             next_cycle;

   always_comb begin
      decoded = core_decode_pkg::OPK_OTHER;
      if (i_instr[core_decode_pkg::INSTR_W-1:core_decode_pkg::OPC_JUMP_LSB]
          == core_decode_pkg::OPC_JUMP) begin
         decoded = core_decode_pkg::OPK_JUMP;
      end else if (i_instr[core_decode_pkg::INSTR_W-1:core_decode_pkg::OPC_INC_LSB]
                   == core_decode_pkg::OPC_INC) begin
         decoded = core_decode_pkg::OPK_INC;
      end else if ((i_instr & core_decode_pkg::IDLE_MASK) == core_decode_pkg::IDLE_CODE) begin
         decoded = core_decode_pkg::OPK_IDLE;
      end
   end

   always_comb begin
      next_ir          = ir;
      next_operand     = operand;
      next_result      = result;
      next_pc          = o_pc;
      next_w           = o_w;
      next_zero        = o_zero;
      next_op_kind     = o_op_kind;
      next_cycle       = o_cycle;
      next_file_req    = o_file_req;
      next_file_req.we = 1'b0;
      if (step) begin
         case (phase)
            core_decode_pkg::PH_Q1: begin
               if (o_cycle == core_decode_pkg::CYC_EXEC) begin
                  next_ir            = i_instr;
                  next_op_kind       = decoded;
                  next_file_req.addr = i_instr[core_decode_pkg::FADDR_W-1:0];
               end else begin
                  // second jump cycle executes as idle
                  next_ir      = core_decode_pkg::IDLE_CODE;
                  next_op_kind = core_decode_pkg::OPK_IDLE;
               end
            end
            core_decode_pkg::PH_Q2: begin
               next_operand = i_file_rdata;
            end
            core_decode_pkg::PH_Q3: begin
               next_result = operand + core_decode_pkg::DATA_ONE;
            end
            core_decode_pkg::PH_Q4: begin
               next_cycle = core_decode_pkg::CYC_EXEC;
               case (o_op_kind)
                  core_decode_pkg::OPK_JUMP: begin
                     next_pc = {i_pc_upper_latch[core_decode_pkg::LATCH_HI:core_decode_pkg::LATCH_LO],
                                ir[core_decode_pkg::LIT_W-1:0]};
                     next_cycle = core_decode_pkg::CYC_FLUSH;
                  end
                  core_decode_pkg::OPK_INC: begin
                     next_zero = (result == core_decode_pkg::DATA_RESET);
                     if (ir[core_decode_pkg::DEST_BIT]) begin
                        next_file_req.we    = 1'b1;
                        next_file_req.wdata = result;
                     end else begin
                        next_w = result;
                     end
                     next_pc = o_pc + core_decode_pkg::PC_ONE;
                  end
                  default: begin
                     // flush cycle holds pc while the target is fetched
                     if (o_cycle == core_decode_pkg::CYC_EXEC) begin
                        next_pc = o_pc + core_decode_pkg::PC_ONE;
                     end
                  end
               endcase
            end
            default: begin
               next_cycle = o_cycle;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ir         <= core_decode_pkg::IDLE_CODE;
         operand    <= core_decode_pkg::DATA_RESET;
         result     <= core_decode_pkg::DATA_RESET;
         o_pc       <= core_decode_pkg::PC_RESET;
         o_w        <= core_decode_pkg::DATA_RESET;
         o_zero     <= 1'b0;
         o_op_kind  <= core_decode_pkg::OPK_IDLE;
         o_cycle    <= core_decode_pkg::CYC_EXEC;
         o_file_req <= '0;
      end else begin
         ir         <= next_ir;
         operand    <= next_operand;
         result     <= next_result;
         o_pc       <= next_pc;
         o_w        <= next_w;
         o_zero     <= next_zero;
         o_op_kind  <= next_op_kind;
         o_cycle    <= next_cycle;
         o_file_req <= next_file_req;
      end
   end

   // =======================================================================
   // checks
   // =======================================================================
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);

   logic q1_exec;
   logic q4_end;
   assign q1_exec = step && (phase == core_decode_pkg::PH_Q1)
                    && (o_cycle == core_decode_pkg::CYC_EXEC);
   assign q4_end  = step && (phase == core_decode_pkg::PH_Q4);

   sequence flush_quiet_s;
      (o_cycle == core_decode_pkg::CYC_FLUSH && !o_file_req.we)[*8];
   endsequence

   sequence back_to_exec_s;
      (o_cycle == core_decode_pkg::CYC_EXEC) && $stable(o_pc);
   endsequence

   jump_decode_a: assert property (
      q1_exec && i_instr[13:11] == 3'h5 |=> o_op_kind == core_decode_pkg::OPK_JUMP)
      else $error("jump opcode not decoded");

   jump_low_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_JUMP |=> o_pc[10:0] == $past(ir[10:0]))
      else $error("jump literal not loaded into pc");

   jump_high_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_JUMP
      |=> o_pc[12:11] == $past(i_pc_upper_latch[4:3]))
      else $error("pc upper bits not from latch");

   jump_flush_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_JUMP |=> flush_quiet_s ##1 back_to_exec_s)
      else $error("jump second cycle not idle");

   inc_zero_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_INC
      |=> o_zero == ($past(result) == 8'h00) && result == $past(operand, 3) + 8'h01)
      else $error("increment result or zero flag wrong");

   inc_dest_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_INC
      |=> (ir[7] ? (o_file_req.we && o_file_req.wdata == $past(result)
                    && o_file_req.addr == ir[6:0] && $stable(o_w))
                 : (!o_file_req.we && o_w == $past(result))))
      else $error("increment destination wrong");

   inc_single_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_INC
      |=> o_cycle == core_decode_pkg::CYC_EXEC && o_pc == $past(o_pc) + 13'h0001
          ##1 !o_file_req.we)
      else $error("increment not single cycle");

   idle_quiet_a: assert property (
      q4_end && o_op_kind == core_decode_pkg::OPK_IDLE && o_cycle == core_decode_pkg::CYC_EXEC
      |=> $stable(o_w) && $stable(o_zero) && !o_file_req.we && o_pc == $past(o_pc) + 13'h0001)
      else $error("idle instruction changed state");

endmodule : branch_increment_nop_decode

// ==== branch_increment_nop_decode_tb_top.sv ====
`timescale 1ns/10ps
module branch_increment_nop_decode_tb_top;
   // ======================================================================
   // signals, program memory and file registers
   // ======================================================================
   logic                                     i_sys_clk;
   logic                                     i_reset_n;
   logic [core_decode_pkg::INSTR_W-1:0]      i_instr;
   logic [core_decode_pkg::LATCH_W-1:0]      i_pc_upper_latch;
   logic [core_decode_pkg::DATA_W-1:0]       i_file_rdata;
   logic [core_decode_pkg::PC_W-1:0]         o_pc;
   core_decode_pkg::file_port_s              o_file_req;
   logic [core_decode_pkg::DATA_W-1:0]       o_w;
   logic                                     o_zero;
   core_decode_pkg::op_kind_e                o_op_kind;
   core_decode_pkg::cycle_e                  o_cycle;
   logic [13:0]                              prog [0:8191];
   logic [7:0]                               file [0:127];
   int                                       n_mismatch;
   int                                       n_checks;
   int                                       n_we;
   int                                       n_clk;
   int                                       c;

   branch_increment_nop_decode u_dut (
      .i_sys_clk        (i_sys_clk),
      .i_reset_n        (i_reset_n),
      .i_instr          (i_instr),
      .i_pc_upper_latch (i_pc_upper_latch),
      .o_pc             (o_pc),
      .i_file_rdata     (i_file_rdata),
      .o_file_req       (o_file_req),
      .o_w              (o_w),
      .o_zero           (o_zero),
      .o_op_kind        (o_op_kind),
      .o_cycle          (o_cycle)
   );

   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // cycle ceiling: a stuck scenario ends the run as a failure
   always @(posedge i_sys_clk) begin
      n_clk++;
      if (n_clk >= 3000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // memory models: fetch at o_pc, file read at request address,
   // a write lands at the edge that samples we high
   always @(posedge i_sys_clk) begin
      if (o_file_req.we === 1'b1) begin
         file[o_file_req.addr] = o_file_req.wdata;
         n_we++;
      end
      #1;
      i_instr = prog[o_pc];
      i_file_rdata = file[o_file_req.addr];
   end

   // ======================================================================
   // helpers
   // ======================================================================
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic reset_dut(input int n);
      @(posedge i_sys_clk);
      #1 i_reset_n = 1'b0;
      repeat (n) @(posedge i_sys_clk);
      #1 i_reset_n = 1'b1;
   endtask : reset_dut

   // counts clocks until the program counter shows the target
   task automatic wait_pc(input logic [12:0] target, output int cnt);
      cnt = 0;
      while (o_pc !== target && cnt < 100) begin
         @(posedge i_sys_clk);
         #1;
         cnt++;
      end
      if (o_pc !== target) begin
         n_mismatch++;
         $display("Error pc_reached expected %h seen %h", target, o_pc);
      end
   endtask : wait_pc

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // ======================================================================
   // scenarios
   // ======================================================================
   task automatic idle_test(input int n);
      logic [1:0] kinds [0:4];
      kinds = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
      prog[0] = 14'h0000;
      prog[1] = 14'h0020;
      prog[2] = 14'h0040;
      prog[3] = 14'h0060;
      prog[4] = 14'h2123;
      prog[5] = 14'h0080;
      reset_dut(n);
      wait_pc(13'h0001, c);
      n_we = 0;
      for (int i = 2; i <= 6; i++) begin
         wait_pc(13'(i), c);
         chk("idle_cycle_len", 16'h0008, 16'(c));
         chk("op_kind", 16'(kinds[i-2]), 16'(o_op_kind));
      end
      chk("w_after_idle", 16'h0000, 16'(o_w));
      chk("zero_after_idle", 16'h0000, 16'(o_zero));
      chk("writes_after_idle", 16'h0000, 16'(n_we));
   endtask : idle_test

   task automatic inc_test(input int n);
      file[5] = 8'hff;
      file[127] = 8'h41;
      prog[0] = 14'h0000;
      prog[1] = 14'h0a85;
      prog[2] = 14'h0a05;
      prog[3] = 14'h0a7f;
      prog[4] = 14'h0000;
      reset_dut(n);
      wait_pc(13'h0001, c);
      n_we = 0;
      wait_pc(13'h0002, c);
      chk("inc_cycle_len", 16'h0008, 16'(c));
      chk("op_kind_inc", 16'(core_decode_pkg::OPK_INC), 16'(o_op_kind));
      chk("zero_set", 16'h0001, 16'(o_zero));
      chk("w_kept", 16'h0000, 16'(o_w));
      // the file write lands one clock after the pc update
      @(posedge i_sys_clk);
      #1;
      chk("file5_wrap", 16'h0000, 16'(file[5]));
      wait_pc(13'h0003, c);
      chk("w_inc", 16'h0001, 16'(o_w));
      chk("zero_clear", 16'h0000, 16'(o_zero));
      chk("file5_kept", 16'h0000, 16'(file[5]));
      wait_pc(13'h0004, c);
      chk("w_inc_top_addr", 16'h0042, 16'(o_w));
      chk("file127_kept", 16'h0041, 16'(file[127]));
      chk("write_count", 16'h0001, 16'(n_we));
   endtask : inc_test

   task automatic jump_test(input int n);
      i_pc_upper_latch = 8'hf7;
      file[6] = 8'h10;
      prog[0] = 14'h0000;
      prog[1] = 14'h2da5;
      prog[13'h15a5] = 14'h0a86;
      prog[13'h15a6] = 14'h2fff;
      reset_dut(n);
      wait_pc(13'h0001, c);
      wait_pc(13'h15a5, c);
      chk("jump_target_time", 16'h0008, 16'(c));
      chk("op_kind_jump", 16'(core_decode_pkg::OPK_JUMP), 16'(o_op_kind));
      chk("flush_cycle", 16'(core_decode_pkg::CYC_FLUSH), 16'(o_cycle));
      i_pc_upper_latch = 8'h08;
      wait_pc(13'h15a6, c);
      chk("flush_len", 16'h0010, 16'(c));
      chk("w_after_jump", 16'h0000, 16'(o_w));
      wait_pc(13'h0fff, c);
      chk("jump_upper_bits", 16'h0008, 16'(c));
      chk("second_flush", 16'(core_decode_pkg::CYC_FLUSH), 16'(o_cycle));
      chk("file6_once", 16'h0011, 16'(file[6]));
   endtask : jump_test

   initial begin
      i_reset_n = 1'b0;
      i_instr = 14'h0000;
      i_pc_upper_latch = 8'h00;
      i_file_rdata = 8'h00;
      n_mismatch = 0;
      n_checks = 0;
      n_we = 0;
      n_clk = 0;
      idle_test(20);
      inc_test(2);
      jump_test(2);
      finish_test();
   end
endmodule : branch_increment_nop_decode_tb_top
